// ==== rtl/capture_cfg_pkg.sv ====
/*
 * Shared constants for the input capture channel configuration block:
 * register offsets, field positions, reset values and filter decoding.
 * Assumes a 32-bit APB register bus and a single kernel clock.
 */
package capture_cfg_pkg;

	// =====================================================================
	// register map
	localparam logic [7:0]  MODE_OFFSET      = 8'h00;
	localparam logic [7:0]  ENABLE_OFFSET    = 8'h04;
	localparam logic [7:0]  TRIGGER_OFFSET   = 8'h08;
	localparam logic [7:0]  STATUS_OFFSET    = 8'h0C;

	localparam logic [15:0] MODE_RESET       = 16'h0000;
	localparam logic [3:0]  ENABLE_RESET     = 4'h0;
	localparam logic [2:0]  TRIGGER_RESET    = 3'h0;

	// =====================================================================
	// mode register fields
	localparam int CH1_SEL_LSB    = 0;
	localparam int CH1_DIV_LSB    = 2;
	localparam int CH1_FILTER_LSB = 4;
	localparam int CH2_SEL_LSB    = 8;
	localparam int CH2_DIV_LSB    = 10;
	localparam int CH2_FILTER_LSB = 12;

	// enable register fields
	localparam int CH1_ENABLE_BIT   = 0;
	localparam int CH2_ENABLE_BIT   = 1;
	localparam int CH1_FALLING_BIT  = 2;
	localparam int CH2_FALLING_BIT  = 3;

	// trigger select codes below this pick an internal trigger input
	localparam logic [2:0] TRIGGER_INTERNAL_LIMIT = 3'h4;

	// =====================================================================
	// direction select codes
	localparam logic [1:0] SEL_OUTPUT  = 2'h0;
	localparam logic [1:0] SEL_OWN     = 2'h1;
	localparam logic [1:0] SEL_OTHER   = 2'h2;
	localparam logic [1:0] SEL_TRIGGER = 2'h3;

	localparam logic [3:0] FILTER_OFF     = 4'h0;
	localparam logic [3:0] FILTER_DTS_MIN = 4'h4;

	// =====================================================================
	// filter decoding: consecutive samples needed
	function automatic logic [3:0] filter_samples(input logic [3:0] code);
		unique case (code)
			4'h0: filter_samples = 4'h1;
			4'h1: filter_samples = 4'h2;
			4'h2: filter_samples = 4'h4;
			4'h3: filter_samples = 4'h8;
			4'h4, 4'h6, 4'h8: filter_samples = 4'h6;
			4'hA, 4'hD: filter_samples = 4'h5;
			4'hB, 4'hE: filter_samples = 4'h6;
			default: filter_samples = 4'h8;
		endcase
	endfunction : filter_samples

	// filter decoding: log2 of the dead-time clock divisor
	function automatic logic [2:0] filter_div_log(input logic [3:0] code);
		unique case (code)
			4'h4, 4'h5: filter_div_log = 3'h1;
			4'h6, 4'h7: filter_div_log = 3'h2;
			4'h8, 4'h9: filter_div_log = 3'h3;
			4'hA, 4'hB, 4'hC: filter_div_log = 3'h4;
			4'hD, 4'hE, 4'hF: filter_div_log = 3'h5;
			default: filter_div_log = 3'h0;
		endcase
	endfunction : filter_div_log

endpackage : capture_cfg_pkg

// ==== rtl/input_filter.sv ====
/*
 * Digital input filter for one timer input: picks a sampling rate and
 * a run length from a 4-bit code and moves its level after a run of
 * agreeing samples. Assumes dts_tick pulses once per dead-time clock.
 */
`timescale 1ns/1ps

module input_filter
	import capture_cfg_pkg::*;
(
	input  wire logic       clock,    // kernel clock
	input  wire logic       rst_b,    // async reset, active low
	input  wire logic       ce,       // clock enable
	input  wire logic       dts_tick, // dead-time clock strobe
	input  wire logic [3:0] code,     // filter setting
	input  wire logic       raw,      // unfiltered input
	output logic            level     // filtered level
);

	// =====================================================================
	// sampling strobe
	logic [4:0] div_q;
	logic [4:0] div_mask;
	logic       sample;
	logic [3:0] need;
	logic [2:0] cnt_q;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			div_q <= 5'h00;
		end else if (ce && dts_tick) begin
			div_q <= div_q + 5'h01;
		end
	end

	assign div_mask = 5'((6'h01 << filter_div_log(code)) - 6'h01);
	assign need     = filter_samples(code);

	always_comb begin
		if (code == FILTER_OFF) begin
			sample = dts_tick;
		end else if (code < FILTER_DTS_MIN) begin
			sample = 1'b1;
		end else begin
			sample = dts_tick && ((div_q & div_mask) == 5'h00);
		end
	end

	// =====================================================================
	// run counter
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 3'h0;
			level <= 1'b0;
		end else if (ce && sample) begin
			if (code == FILTER_OFF) begin
				level <= raw;
				cnt_q <= 3'h0;
			end else if (raw == level) begin
				cnt_q <= 3'h0;
			end else if (({1'b0, cnt_q} + 4'h1) == need) begin
				level <= raw;
				cnt_q <= 3'h0;
			end else begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end

	// =====================================================================
	// checks
	sequence s_first_miss;
		ce && code == 4'h1 && cnt_q == 3'h0 && raw != level;
	endsequence

	sequence s_second_miss;
		ce && code == 4'h1 && raw != level && raw == $past(raw);
	endsequence

	AST_FILTER_OFF_FOLLOWS: assert property (
		@(posedge clock) disable iff (!rst_b)
		(ce && code == FILTER_OFF && dts_tick) |=> level == $past(raw))
		else $error("unfiltered input not taken on dead-time strobe");

	AST_FILTER_ONLY_AFTER_RUN: assert property (
		@(posedge clock) disable iff (!rst_b)
		$changed(level) |-> $past(code == FILTER_OFF || ({1'b0, cnt_q} + 4'h1) == need))
		else $error("filtered level moved before its run completed");

	AST_FILTER_TWO_SAMPLES: assert property (
		@(posedge clock) disable iff (!rst_b)
		s_first_miss ##1 s_second_miss |=> level == $past(raw))
		else $error("two agreeing kernel samples did not move the level");

endmodule : input_filter

// ==== rtl/capture_channel_config.sv ====
/*
 * Input capture configuration for timer channels 1 and 2: APB register
 * bank, direction and input mapping, input filters, edge detection and
 * capture prescalers. Assumes timer inputs and the internal trigger are
 * synchronous to clock, and dts_tick marks the dead-time clock rate.
 */
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps

// Behaviour
// - Channel 2 select code 00 is output, 01 takes timer input 2, 10 takes timer input 1.
// - Channel 2 select code 11 takes the internal trigger, only while an internal trigger is selected.
// - Writes to the channel 2 select field are ignored while channel 2 is enabled.
// - Channel 1 select code 00 is output, 01 takes timer input 1, 10 takes timer input 2.
// - Channel 1 select code 11 takes the internal trigger, only while an internal trigger is selected.
// - The filter moves its level only after N consecutive samples agree with the new level.
// - Filter code 0000 does no filtering and samples at the dead-time clock rate.
// - Filter codes 0001 to 0011 sample every kernel clock and need 2, 4 and 8 samples.
// - Filter codes 0100 to 1001 sample at dead-time clock over 2, 4 and 8, needing 6 then 8.
// - Filter codes 1010 to 1111 sample at dead-time clock over 16 and 32, needing 5, 6 and 8.
// - Capture divider code 00 captures every edge, 01, 10 and 11 every 2, 4 and 8 edges.
// - The channel 1 divider counter is held cleared while channel 1 is disabled.
// - The channel 2 filter setting is four bits at mode register bits 15 to 12.
// - The channel 2 capture divider is two bits at mode register bits 11 to 10.
module capture_channel_config
	import capture_cfg_pkg::*;
#(
	parameter int CNT_W = 8                   // capture counter width
)(
	input  wire logic        clock,                   // kernel clock, 100 MHz
	input  wire logic        rst_b,                   // async reset, active low
	input  wire logic        ce,                      // clock enable
	input  wire logic        dts_tick,                // dead-time clock strobe
	input  wire logic        timer_input_1,           // timer input pin 1
	input  wire logic        timer_input_2,           // timer input pin 2
	input  wire logic        internal_trigger_signal, // internal trigger
	input  wire logic        psel,                    // apb select
	input  wire logic        penable,                 // apb enable
	input  wire logic        pwrite,                  // apb direction
	input  wire logic [7:0]  paddr,                   // apb byte address
	input  wire logic [31:0] pwdata,                  // apb write data
	output logic      [31:0] prdata,                  // apb read data
	output logic             pready,                  // apb ready
	output logic             pslverr,                 // apb error
	output logic             ch1_capture,             // channel 1 capture pulse
	output logic             ch2_capture              // channel 2 capture pulse
);

	generate
		if (CNT_W < 1 || CNT_W > 8) begin : g_bad_width
			$error("CNT_W must lie in 1..8");
		end
	endgenerate

	// =====================================================================
	// registers
	logic [15:0]      mode_q;
	logic [3:0]       enable_q;
	logic [2:0]       trigger_select_field;
	logic [CNT_W-1:0] capture_count_q [2];

	logic [1:0] ch1_direction_select;
	logic [1:0] ch2_direction_select;
	logic [1:0] ch1_capture_divider;
	logic [1:0] ch2_capture_divider;
	logic [3:0] ch1_input_filter;
	logic [3:0] ch2_input_filter;
	logic       ch1_enable;
	logic       ch2_enable;
	logic       trigger_internal;
	logic [1:0] filtered;

	assign ch1_direction_select = mode_q[CH1_SEL_LSB +: 2];
	assign ch1_capture_divider  = mode_q[CH1_DIV_LSB +: 2];
	assign ch1_input_filter     = mode_q[CH1_FILTER_LSB +: 4];
	assign ch2_direction_select = mode_q[CH2_SEL_LSB +: 2];
	assign ch2_capture_divider  = mode_q[CH2_DIV_LSB +: 2];
	assign ch2_input_filter     = mode_q[CH2_FILTER_LSB +: 4];
	assign ch1_enable           = enable_q[CH1_ENABLE_BIT];
	assign ch2_enable           = enable_q[CH2_ENABLE_BIT];
	assign trigger_internal     = trigger_select_field < TRIGGER_INTERNAL_LIMIT;

	// =====================================================================
	// apb slave: answers in the second access cycle
	logic       access;
	logic       fire;
	logic       wr_fire;
	logic       mapped;
	logic [15:0] mode_d;
	logic [31:0] rdata_d;

	assign access  = psel && penable;
	assign fire    = access && pready;
	assign wr_fire = fire && pwrite;

	always_comb begin
		mapped  = 1'b1;
		rdata_d = 32'h0000_0000;
		unique case (paddr)
			MODE_OFFSET:    rdata_d[15:0] = mode_q;
			ENABLE_OFFSET:  rdata_d[3:0]  = enable_q;
			TRIGGER_OFFSET: rdata_d[2:0]  = trigger_select_field;
			STATUS_OFFSET: begin
				rdata_d[0]      = filtered[0];
				rdata_d[1]      = filtered[1];
				rdata_d[15:8]   = 8'(capture_count_q[0]);
				rdata_d[23:16]  = 8'(capture_count_q[1]);
			end
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready  <= access && !pready;
			pslverr <= access && !pready && !mapped;
			prdata  <= (access && !pready && !pwrite) ? rdata_d : 32'h0000_0000;
		end
	end

	// select fields are frozen while their channel is on
	always_comb begin
		mode_d = pwdata[15:0];
		if (ch1_enable) begin
			mode_d[CH1_SEL_LSB +: 2] = ch1_direction_select;
		end
		if (ch2_enable) begin
			mode_d[CH2_SEL_LSB +: 2] = ch2_direction_select;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= MODE_RESET;
		end else if (ce && wr_fire && paddr == MODE_OFFSET) begin
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			enable_q             <= ENABLE_RESET;
			trigger_select_field <= TRIGGER_RESET;
		end else if (ce && wr_fire) begin
			if (paddr == ENABLE_OFFSET) begin
				enable_q <= pwdata[3:0];
			end
			if (paddr == TRIGGER_OFFSET) begin
				trigger_select_field <= pwdata[2:0];
			end
		end
	end

	// =====================================================================
	// filters and input mapping
	logic [1:0] source;
	logic [1:0] sel    [2];
	logic [1:0] divider [2];
	logic [1:0] enable;
	logic [1:0] falling;
	logic [1:0] pins;
	logic [3:0] fcode  [2];

	assign pins       = {timer_input_2, timer_input_1};
	assign sel[0]     = ch1_direction_select;
	assign sel[1]     = ch2_direction_select;
	assign divider[0] = ch1_capture_divider;
	assign divider[1] = ch2_capture_divider;
	assign fcode[0]   = ch1_input_filter;
	assign fcode[1]   = ch2_input_filter;
	assign enable     = {ch2_enable, ch1_enable};
	assign falling    = {enable_q[CH2_FALLING_BIT], enable_q[CH1_FALLING_BIT]};

	// maps a select code to a source for channel ch
	function automatic logic pick(input logic [1:0] code, input logic own, input logic other,
		input logic trig, input logic trig_ok);
		unique case (code)
			SEL_OUTPUT:  pick = 1'b0;
			SEL_OWN:     pick = own;
			SEL_OTHER:   pick = other;
			SEL_TRIGGER: pick = trig_ok && trig;
		endcase
	endfunction : pick

	logic [1:0]       prev_q;
	logic [1:0]       edge_hit;
	logic [2:0]       psc_q [2];
	logic [1:0]       capture_q;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			input_filter u_filter (
				.clock    (clock),
				.rst_b    (rst_b),
				.ce       (ce),
				.dts_tick (dts_tick),
				.code     (fcode[ch]),
				.raw      (pins[ch]),
				.level    (filtered[ch])
			);

			assign source[ch] = pick(sel[ch], filtered[ch], filtered[1-ch],
				internal_trigger_signal, trigger_internal);

			// filtered input or internal trigger edges of the chosen polarity
			assign edge_hit[ch] = (sel[ch] != SEL_OUTPUT) && (source[ch] != prev_q[ch])
				&& (source[ch] == !falling[ch]);

			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					prev_q[ch] <= 1'b0;
				end else if (ce) begin
					prev_q[ch] <= source[ch];
				end
			end

			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					psc_q[ch]           <= 3'h0;
					capture_q[ch]       <= 1'b0;
					capture_count_q[ch] <= '0;
				end else if (ce) begin
					capture_q[ch] <= 1'b0;
					if (!enable[ch]) begin
						psc_q[ch] <= 3'h0;
					end else if (edge_hit[ch]) begin
						if (psc_q[ch] == 3'((4'h1 << divider[ch]) - 4'h1)) begin
							psc_q[ch]           <= 3'h0;
							capture_q[ch]       <= 1'b1;
							capture_count_q[ch] <= capture_count_q[ch] + 1'b1;
						end else begin
							psc_q[ch] <= psc_q[ch] + 3'h1;
						end
					end
				end
			end
		end
	endgenerate

	assign ch1_capture = capture_q[0];
	assign ch2_capture = capture_q[1];

	// =====================================================================
	// checks
	sequence s_ch2_sel_write;
		ce && wr_fire && paddr == MODE_OFFSET && ch2_enable;
	endsequence

	AST_CH2_SEL_LOCKED: assert property (
		@(posedge clock) disable iff (!rst_b)
		s_ch2_sel_write |=> $stable(ch2_direction_select))
		else $error("channel 2 select changed while enabled");

	AST_CH1_DIVIDER_CLEARED: assert property (
		@(posedge clock) disable iff (!rst_b)
		(ce && !ch1_enable) |=> psc_q[0] == 3'h0 && !ch1_capture)
		else $error("channel 1 divider counted while disabled");

	AST_CH2_DIVIDER_CLEARED: assert property (
		@(posedge clock) disable iff (!rst_b)
		(ce && !ch2_enable) |=> psc_q[1] == 3'h0 && !ch2_capture)
		else $error("channel 2 divider counted while disabled");

	AST_CH2_OUTPUT_NO_CAPTURE: assert property (
		@(posedge clock) disable iff (!rst_b)
		ch2_capture |-> $past(ch2_direction_select) != SEL_OUTPUT)
		else $error("channel 2 captured in output mode");

	AST_CH2_TRIGGER_GATED: assert property (
		@(posedge clock) disable iff (!rst_b)
		(ch2_direction_select == SEL_TRIGGER)
			|-> source[1] == (trigger_internal && internal_trigger_signal))
		else $error("channel 2 trigger mapping wrong");

	AST_CH1_TRIGGER_GATED: assert property (
		@(posedge clock) disable iff (!rst_b)
		(ch1_direction_select == SEL_TRIGGER)
			|-> source[0] == (trigger_internal && internal_trigger_signal))
		else $error("channel 1 trigger mapping wrong");

	AST_CH1_MAP: assert property (
		@(posedge clock) disable iff (!rst_b)
		(ch1_direction_select == SEL_OTHER) |-> source[0] == filtered[1])
		else $error("channel 1 not mapped to timer input 2");

	AST_EVERY_EDGE: assert property (
		@(posedge clock) disable iff (!rst_b)
		(ce && ch1_enable && ch1_capture_divider == 2'h0 && edge_hit[0]) |=> ch1_capture)
		else $error("divider code 00 skipped an edge");

endmodule : capture_channel_config

// ==== bench/input_source_model.sv ====
/*
 * Behavioural source for the timer input pins and the internal trigger.
 * Assumes the bench calls its tasks and that all levels follow the kernel clock.
 */
`timescale 1ns/1ps

module input_source_model (
	input  wire logic clock,                   // kernel clock
	output logic      timer_input_1,           // timer input pin 1
	output logic      timer_input_2,           // timer input pin 2
	output logic      internal_trigger_signal  // internal trigger
);

	// ==========
	// idle levels
	initial begin
		timer_input_1           = 1'b0;
		timer_input_2           = 1'b0;
		internal_trigger_signal = 1'b0;
	end

	// ==========
	// level changes, always just after an edge
	task automatic drive(input logic [2:0] mask);
		@(posedge clock);
		timer_input_1           <= mask[0];
		timer_input_2           <= mask[1];
		internal_trigger_signal <= mask[2];
	endtask : drive

	// high for width cycles, then low for as long
	task automatic pulse(input logic [2:0] mask, input int width);
		drive(mask);
		repeat (width - 1) @(posedge clock);
		drive(3'b000);
		repeat (width - 1) @(posedge clock);
	endtask : pulse

endmodule : input_source_model

// ==== bench/input_capture_channel_config_tb_top.sv ====
/*
 * Self-checking bench for the capture channel configuration block.
 * Assumes the design package and the input source model are compiled first.
 */
`timescale 1ns/1ps

module input_capture_channel_config_tb_top;
	import capture_cfg_pkg::*;

	localparam int DTS = 2;

	logic        clock;
	logic        rst_b;
	logic        ce;
	logic        dts_tick = 1'b0;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ch1_capture;
	logic        ch2_capture;
	logic        ti1;
	logic        ti2;
	logic        trig;
	logic [31:0] seed_q;
	logic [31:0] rd;
	logic [31:0] r;
	logic [31:0] old;
	logic        er;
	int          err_total;
	int          checks_done;
	int          cap1 = 0;
	int          cap2 = 0;
	int          b1;
	int          b2;
	int          n;
	int          p;
	int          i;

	capture_channel_config #(.CNT_W(8)) i_capture_channel_config (
		.clock(clock), .rst_b(rst_b), .ce(ce), .dts_tick(dts_tick),
		.timer_input_1(ti1), .timer_input_2(ti2), .internal_trigger_signal(trig),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ch1_capture(ch1_capture), .ch2_capture(ch2_capture));

	input_source_model i_input_source_model (
		.clock(clock), .timer_input_1(ti1), .timer_input_2(ti2), .internal_trigger_signal(trig));

	// ==========
	// clock, dead-time strobe every second cycle, capture counting
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		dts_tick <= ~dts_tick;
		if (ch1_capture === 1'b1) cap1 <= cap1 + 1;
		if (ch2_capture === 1'b1) cap2 <= cap2 + 1;
	end

	// ==========
	// expectations
	function automatic logic [31:0] rnd();
		seed_q = seed_q ^ (seed_q << 13);
		seed_q = seed_q ^ (seed_q >> 17);
		seed_q = seed_q ^ (seed_q << 5);
		return seed_q;
	endfunction : rnd

	function automatic int filt_n(input int c);
		case (c)
			0: return 1;
			1: return 2;
			2: return 4;
			4, 6, 8, 11, 14: return 6;
			10, 13: return 5;
			default: return 8;
		endcase
	endfunction : filt_n

	function automatic int filt_p(input int c);
		if (c == 0) return DTS;
		if (c < 4) return 1;
		if (c < 10) return DTS << ((c - 2) / 2);
		return (c < 13) ? DTS * 16 : DTS * 32;
	endfunction : filt_p

	function automatic int src(input int sel, input logic own, input logic oth, input logic trg);
		case (sel)
			1: return int'(own);
			2: return int'(oth);
			3: return int'(trg);
			default: return 0;
		endcase
	endfunction : src

	// ==========
	// bus cycles and comparisons
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish

	task automatic miss(input string msg);
		err_total++;
		$display("wrong value at %0t: %s", $time, msg);
	endtask : miss

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			miss("no ready");
			tally_and_finish();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic check_reg(input logic [7:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0000_0000);
		checks_done++;
		if (rd !== exp || er !== e) miss($sformatf("reg %h read %h", a, rd));
	endtask : check_reg

	task automatic check_cnt(input int got, input int exp, input string what);
		checks_done++;
		if (got != exp) miss($sformatf("%s count %0d want %0d", what, got, exp));
	endtask : check_cnt

	// ==========
	// main sequence
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		ce = 1'b1;
		err_total = 0;
		checks_done = 0;
		seed_q = 32'h0001_2db6;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		for (i = 0; i < 4; i++) check_reg(8'(4 * i), 32'h0000_0000, 1'b0);
		check_reg(8'h10, 32'h0000_0000, 1'b1);
		repeat (4) begin
			r = rnd();
			wr(MODE_OFFSET, r);
			check_reg(MODE_OFFSET, {16'h0000, r[15:0]}, 1'b0);
		end
		old = r;
		wr(ENABLE_OFFSET, 32'h0000_0003);
		r = rnd();
		wr(MODE_OFFSET, r);
		check_reg(MODE_OFFSET, {16'h0000, r[15:10], old[9:8], r[7:2], old[1:0]}, 1'b0);
		$display("end of register tests");
		for (i = 0; i < 32; i++) begin
			r = rnd();
			wr(ENABLE_OFFSET, 32'h0000_0000);
			wr(TRIGGER_OFFSET, {29'h0, r[2:0]});
			wr(MODE_OFFSET, {16'h0000, 6'h04, i[3:2], 6'h04, i[1:0]});
			wr(ENABLE_OFFSET, 32'h0000_0003);
			b1 = cap1;
			b2 = cap2;
			i_input_source_model.pulse({1'b1, r[5:4]}, 6);
			repeat (8) @(posedge clock);
			check_cnt(cap1 - b1, src(i % 4, r[4], r[5], r[2:0] < TRIGGER_INTERNAL_LIMIT), "ch1 map");
			check_cnt(cap2 - b2, src((i / 4) % 4, r[5], r[4], r[2:0] < TRIGGER_INTERNAL_LIMIT), "ch2 map");
		end
		for (i = 0; i < 2; i++) begin
			wr(ENABLE_OFFSET, 32'h0000_0000);
			wr(MODE_OFFSET, 32'h0000_0011);
			wr(ENABLE_OFFSET, 32'(1 + 4 * i));
			b1 = cap1;
			i_input_source_model.drive(3'b001);
			repeat (8) @(posedge clock);
			check_cnt(cap1 - b1, 1 - i, "rise");
			i_input_source_model.drive(3'b000);
			repeat (8) @(posedge clock);
			check_cnt(cap1 - b1, 1, "fall");
		end
		// clock enable low: the pulse must leave no trace
		ce <= 1'b0;
		b1 = cap1;
		i_input_source_model.pulse(3'b001, 6);
		ce <= 1'b1;
		repeat (8) @(posedge clock);
		check_cnt(cap1 - b1, 0, "frozen");
		$display("end of mapping tests");
		for (i = 0; i < 4; i++) begin
			wr(ENABLE_OFFSET, 32'h0000_0000);
			wr(MODE_OFFSET, {16'h0000, 4'h1, i[1:0], 2'h1, 4'h1, i[1:0], 2'h1});
			wr(ENABLE_OFFSET, 32'h0000_0003);
			b1 = cap1;
			b2 = cap2;
			repeat (8) i_input_source_model.pulse(3'b011, 6);
			repeat (8) @(posedge clock);
			check_cnt(cap1 - b1, 8 >> i, "ch1 divider");
			check_cnt(cap2 - b2, 8 >> i, "ch2 divider");
		end
		repeat (5) i_input_source_model.pulse(3'b011, 6);
		wr(ENABLE_OFFSET, 32'h0000_0000);
		wr(ENABLE_OFFSET, 32'h0000_0003);
		b1 = cap1;
		b2 = cap2;
		repeat (3) i_input_source_model.pulse(3'b011, 6);
		repeat (8) @(posedge clock);
		check_cnt(cap1 - b1, 0, "ch1 cleared");
		check_cnt(cap2 - b2, 0, "ch2 cleared");
		$display("end of divider tests");
		for (i = 0; i < 16; i++) begin
			n = filt_n(i);
			p = filt_p(i);
			wr(ENABLE_OFFSET, 32'h0000_0000);
			wr(MODE_OFFSET, 32'(16 * i + 1));
			wr(ENABLE_OFFSET, 32'h0000_0001);
			b1 = cap1;
			if (n > 1) begin
				r = rnd();
				i_input_source_model.pulse(3'b001, 1 + int'(r % ((n - 1) * p)));
				repeat ((n + 2) * p + 8) @(posedge clock);
				check_cnt(cap1 - b1, 0, "glitch");
			end
			i_input_source_model.pulse(3'b001, (n + 2) * p + 4);
			repeat ((n + 2) * p + 8) @(posedge clock);
			check_cnt(cap1 - b1, 1, "steady");
		end
		$display("end of filter tests");
		tally_and_finish();
	end

endmodule : input_capture_channel_config_tb_top
